// [hw/hdc_config_reg.sv]
/*
 * Haptic drive configuration register with an AHB-Lite slave port.
 * Holds one 8-bit register whose fields steer the drive loop and the input
 * path; fields are also decoded into enables for the downstream logic.
 * Assumes one clock, single-word transfers, and a single-slave bus where
 * hreadyout is the bus hready.
 */
`timescale 1ns/1ns

// Functional notes
// - Bits 7:6 noise gate: off,2%,4%,8%; reset 2
// - Bit 5 rotating mass: 0 closed, 1 open
// - Bit 4 set disables supply compensation
// - Bit 3 live playback data: 0 signed
// - Bit 2 amplitude update once or twice/cycle
// - Bit 1 input type: 0 PWM, 1 analog
// - Bit 0 resonant: auto-track or open, divide 128 with PWM input
module hdc_config_reg
    import hdc_pkg::*;
(
    input wire logic core_clk_i, // 125 MHz core clock
    input wire logic rstn_i, // Asynchronous reset, active low
    input wire logic hsel_i, // Slave select
    input wire logic [31:0] haddr_i, // Byte address
    input wire logic [1:0] htrans_i, // Transfer type
    input wire logic hwrite_i, // Write when high
    input wire logic [2:0] hsize_i, // Transfer size
    input wire logic [31:0] hwdata_i, // Write data
    input wire logic hready_i, // Bus ready
    output logic [31:0] hrdata_o, // Read data
    output logic hreadyout_o, // Always ready
    output logic hresp_o, // Always OKAY
    output hdc_fields_type fields_o, // Decoded fields, registered
    output logic [3:0] gate_percent_o, // Gate threshold in percent, 0 when off
    output logic gate_enable_o, // Noise gate active
    output logic erm_closed_loop_o, // Closed loop with overdrive and braking
    output logic supply_comp_en_o, // Supply compensation enabled
    output logic playback_signed_o, // Live playback data is two's complement
    output logic update_twice_o, // Amplitude update twice per cycle
    output logic analog_input_o, // Input pin in analog mode
    output logic lra_auto_resonance_o, // Resonance tracking active
    output logic [7:0] pwm_divide_o // Divide ratio for open-loop PWM recovery
);

    // Register state and the captured address phase of a pending write
    logic [7:0] cfg; // The configuration register
    logic wr_pend; // Write address phase captured
    logic [HDC_ADDR_BITS-1:0] wr_addr; // Captured write address
    logic rd_hit; // Read address phase valid

    // Maps a gate code to its threshold percentage; used three times below
    // All four codes are legal, so the unique case needs no default
    function automatic logic [3:0] gate_pct(input logic [1:0] code);
        unique case (code)
            HDC_GATE_OFF: gate_pct = 4'h0;
            HDC_GATE_2PCT: gate_pct = HDC_PCT_2;
            HDC_GATE_4PCT: gate_pct = HDC_PCT_4;
            HDC_GATE_8PCT: gate_pct = HDC_PCT_8;
        endcase
    endfunction

    // Valid read transfer in the address phase
    always_comb begin
        rd_hit = hsel_i && hready_i && (htrans_i == HDC_HTRANS_NONSEQ) && !hwrite_i;
    end

    // Capture write address phase; data follows in the next cycle
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else if (hready_i) begin
            // Address kept on every phase; only wr_pend says whether it matters
            wr_pend <= hsel_i && (htrans_i == HDC_HTRANS_NONSEQ) && hwrite_i
                       && (hsize_i == HDC_HSIZE_WORD);
            wr_addr <= haddr_i[HDC_ADDR_BITS-1:0];
        end
    end

    // Register write: whole byte at once, unmapped addresses ignored
    // Only a write data phase loads it, so reads never disturb the register
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg <= HDC_CFG_RESET;
        end else if (wr_pend && wr_addr == HDC_CFG_OFFSET) begin
            cfg <= hwdata_i[7:0];
        end
    end

    // Read data registered in the address phase; reads change no state.
    // Unmapped addresses read as zero, upper bits always zero.
    // A read whose address phase meets a write's data phase sees the old value,
    // because the write only lands at the end of that data phase.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_o <= '0;
        end else if (rd_hit) begin
            if (haddr_i[HDC_ADDR_BITS-1:0] == HDC_CFG_OFFSET) begin
                hrdata_o <= {24'h000000, cfg};
            end else begin
                hrdata_o <= '0;
            end
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Decode fields into registered steering outputs
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // Reset values match the decode of the register's reset value
            fields_o <= hdc_fields_type'(HDC_CFG_RESET);
            gate_percent_o <= gate_pct(HDC_CFG_RESET[HDC_GATE_HI:HDC_GATE_LO]);
            gate_enable_o <= 1'b1;
            erm_closed_loop_o <= 1'b0;
            supply_comp_en_o <= 1'b1;
            playback_signed_o <= 1'b1;
            update_twice_o <= 1'b0;
            analog_input_o <= 1'b0;
            lra_auto_resonance_o <= 1'b1;
            pwm_divide_o <= '0;
        end else begin
            fields_o <= hdc_fields_type'(cfg);
            gate_percent_o <= gate_pct(cfg[HDC_GATE_HI:HDC_GATE_LO]);
            gate_enable_o <= cfg[HDC_GATE_HI:HDC_GATE_LO] != HDC_GATE_OFF;
            // Closed loop is the usual choice; open loop kept for legacy libraries
            erm_closed_loop_o <= !cfg[HDC_ERM_BIT];
            supply_comp_en_o <= !cfg[HDC_COMP_BIT];
            playback_signed_o <= !cfg[HDC_SIGN_BIT];
            update_twice_o <= cfg[HDC_RATE_BIT];
            analog_input_o <= cfg[HDC_INPUT_BIT];
            lra_auto_resonance_o <= !cfg[HDC_LRA_BIT];
            // Divider only matters in open-loop resonant drive with PWM input
            pwm_divide_o <= (cfg[HDC_LRA_BIT] && !cfg[HDC_INPUT_BIT]) ?
                            HDC_PWM_DIVIDE : 8'h00;
        end
    end

    // Assertions
    // Each decode check compares an output with the register one cycle earlier,
    // since every steering output is a flop fed from the register.
    sequence write_phase_s;
        hsel_i && hready_i && htrans_i == HDC_HTRANS_NONSEQ && hwrite_i
            && hsize_i == HDC_HSIZE_WORD && haddr_i[HDC_ADDR_BITS-1:0] == HDC_CFG_OFFSET;
    endsequence

    property write_all_p;
        @(posedge core_clk_i) disable iff (!rstn_i)
        write_phase_s ##1 1'b1 |=> cfg == $past(hwdata_i[7:0]);
    endproperty
    write_update_a: assert property (write_all_p)
        else $error("register did not take written byte");

    read_stable_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !wr_pend |=> $stable(cfg))
        else $error("register changed without a write");

    read_data_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_hit && haddr_i[HDC_ADDR_BITS-1:0] == HDC_CFG_OFFSET
            |=> hrdata_o == {24'h000000, $past(cfg)})
        else $error("read data does not match register");

    gate_decode_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 gate_enable_o == ($past(cfg[HDC_GATE_HI:HDC_GATE_LO]) != HDC_GATE_OFF)
            && gate_percent_o == gate_pct($past(cfg[HDC_GATE_HI:HDC_GATE_LO])))
        else $error("noise gate decode wrong");

    erm_loop_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 erm_closed_loop_o == !$past(cfg[HDC_ERM_BIT]))
        else $error("rotating mass loop select wrong");

    supply_comp_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 supply_comp_en_o != $past(cfg[HDC_COMP_BIT]))
        else $error("supply compensation enable wrong");

    data_sign_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 playback_signed_o != $past(cfg[HDC_SIGN_BIT]))
        else $error("playback signedness wrong");

    update_rate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 update_twice_o == $past(cfg[HDC_RATE_BIT]))
        else $error("amplitude update rate wrong");

    input_type_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 analog_input_o == $past(cfg[HDC_INPUT_BIT]))
        else $error("input type select wrong");

    lra_divide_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 (pwm_divide_o == HDC_PWM_DIVIDE)
            == ($past(cfg[HDC_LRA_BIT]) && !$past(cfg[HDC_INPUT_BIT])))
        else $error("open-loop divide ratio wrong");

    // Resonance tracking runs only while the open-loop bit is clear
    lra_track_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 lra_auto_resonance_o != $past(cfg[HDC_LRA_BIT]))
        else $error("resonance tracking select wrong");

    // The field carrier is a plain copy of the register, one cycle late
    fields_copy_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        ##1 fields_o == hdc_fields_type'($past(cfg)))
        else $error("field carrier does not match register");

    // A write of other than word size must not reach the register
    sequence narrow_write_s;
        hsel_i && hready_i && htrans_i == HDC_HTRANS_NONSEQ && hwrite_i
            && hsize_i != HDC_HSIZE_WORD;
    endsequence

    narrow_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        narrow_write_s |=> !wr_pend ##1 $stable(cfg))
        else $error("narrow write reached the register");

    // Reads away from the register return zero on every bit
    unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_hit && haddr_i[HDC_ADDR_BITS-1:0] != HDC_CFG_OFFSET
            |=> hrdata_o == 32'h00000000)
        else $error("unmapped read returned data");

endmodule

// [hw/hdc_pkg.sv]
/*
 * Package for the haptic drive configuration register block.
 * Holds the register offset, field positions, reset value, AHB-Lite codes
 * and the decoded-field carrier struct. Assumes a 32-bit AHB-Lite fabric.
 */
package hdc_pkg;

    // Index of the configuration register in the word-addressed map
    localparam logic [7:0] HDC_CFG_INDEX = 8'h1d;
    // Byte address: one aligned 32-bit word per index, so four times the index
    localparam logic [7:0] HDC_CFG_OFFSET = {HDC_CFG_INDEX[5:0], 2'h0};
    // Address bits decoded by the slave
    localparam int HDC_ADDR_BITS = 8;

    // Field positions inside the 8-bit register
    localparam int HDC_GATE_HI = 7;
    localparam int HDC_GATE_LO = 6;
    localparam int HDC_ERM_BIT = 5;
    localparam int HDC_COMP_BIT = 4;
    localparam int HDC_SIGN_BIT = 3;
    localparam int HDC_RATE_BIT = 2;
    localparam int HDC_INPUT_BIT = 1;
    localparam int HDC_LRA_BIT = 0;

    // Reset value: gate code 2, rotating mass open loop, all else zero
    localparam logic [7:0] HDC_CFG_RESET = 8'ha0;

    // Noise-gate codes
    localparam logic [1:0] HDC_GATE_OFF = 2'h0;
    localparam logic [1:0] HDC_GATE_2PCT = 2'h1;
    localparam logic [1:0] HDC_GATE_4PCT = 2'h2;
    localparam logic [1:0] HDC_GATE_8PCT = 2'h3;

    // Noise-gate threshold in percent of full scale, per code
    localparam logic [3:0] HDC_PCT_2 = 4'h2;
    localparam logic [3:0] HDC_PCT_4 = 4'h4;
    localparam logic [3:0] HDC_PCT_8 = 4'h8;

    // Frequency divide ratio for open-loop resonant drive from PWM input
    localparam logic [7:0] HDC_PWM_DIVIDE = 8'h80;

    // AHB-Lite transfer codes
    localparam logic [1:0] HDC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HDC_HSIZE_WORD = 3'h2;

    // Decoded configuration fields handed to the drive loop
    typedef struct packed {
        logic [1:0] input_gate_level;
        logic rotating_mass_loop_select;
        logic supply_correction_off;
        logic live_playback_data_signedness;
        logic resonant_amplitude_update_rate;
        logic input_type_select;
        logic resonant_actuator_loop_select;
    } hdc_fields_type;

endpackage

// [sim/hdc_host_model.sv]
/*
 * Host-side bus model: a single-transfer AHB-Lite master that software uses
 * to write and read the configuration register.
 * Assumes one slave whose hreadyout is fed back as the bus hready.
 */
`timescale 1ns/1ns
module hdc_host_model (
    input wire logic clk_i, // Bus clock
    input wire logic hready_i, // Bus ready from the slave
    input wire logic [31:0] hrdata_i, // Read data from the slave
    output logic hsel_o, // Slave select, held high for the only slave
    output logic [31:0] haddr_o, // Byte address
    output logic [1:0] htrans_o, // Transfer type
    output logic hwrite_o, // Write when high
    output logic [2:0] hsize_o, // Transfer size
    output logic [31:0] hwdata_o // Write data
);
    // Idle bus at time zero so no transfer is seen during reset
    initial begin
        hsel_o = 1'b1;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    // One transfer; entered just after a rising edge, never waits a fixed count
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
                        input logic [31:0] d, output logic [31:0] r);
        haddr_o <= a;
        hwrite_o <= w;
        hsize_o <= s;
        htrans_o <= 2'h2;
        // Address phase held until hready is seen high
        do @(posedge clk_i); while (hready_i !== 1'b1);
        htrans_o <= 2'h0;
        hwdata_o <= d;
        // Data phase held likewise; read data taken at that same edge
        do @(posedge clk_i); while (hready_i !== 1'b1);
        r = hrdata_i;
    endtask
endmodule

// [sim/haptic_drive_config_register_test.sv]
/*
 * Self-checking bench for the haptic drive configuration register.
 * Assumes the host model drives the bus and hready is fed from hreadyout.
 */
`timescale 1ns/1ns
module haptic_drive_config_register_test import hdc_pkg::*; ;
    logic core_clk = 1'b0; // 8 ns clock
    logic rstn = 1'b0; // Reset, active low
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    hdc_fields_type fields;
    logic [3:0] gate_percent;
    logic gate_en, erm_cl, comp_en, psigned, twice, analog, lra_auto;
    logic [7:0] pwm_divide;
    logic [7:0] m; // Model of the stored register
    integer seed = 32'h13622263; // Fixed seed keeps runs repeatable
    integer failures = 0, n_tests = 0;
    logic [31:0] d;
    localparam logic [31:0] CFG_ADDR = {24'h000000, HDC_CFG_OFFSET}; // Register byte address
    wire logic [27:0] got_vec = {fields, gate_percent, gate_en, erm_cl, comp_en, psigned,
                                 twice, analog, lra_auto, pwm_divide, hresp};

    hdc_host_model hdc_host_model_inst (.clk_i(core_clk), .hready_i(hreadyout),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    hdc_config_reg hdc_config_reg_inst (.core_clk_i(core_clk), .rstn_i(rstn),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .fields_o(fields),
        .gate_percent_o(gate_percent), .gate_enable_o(gate_en),
        .erm_closed_loop_o(erm_cl), .supply_comp_en_o(comp_en),
        .playback_signed_o(psigned), .update_twice_o(twice), .analog_input_o(analog),
        .lra_auto_resonance_o(lra_auto), .pwm_divide_o(pwm_divide));

    // Free-running clock
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    // Expected steering outputs from a register value; response always OKAY
    function automatic logic [27:0] expect_vec(input logic [7:0] v);
        logic [3:0] pct;
        pct = (v[7:6] == 2'h0) ? 4'h0 : 4'h1 << v[7:6];
        return {v, pct, |v[7:6], ~v[5], ~v[4], ~v[3], v[2], v[1], ~v[0],
                (v[0] & ~v[1]) ? HDC_PWM_DIVIDE : 8'h00, 1'b0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Outputs lag the register by one cycle; compare mid-cycle, then read back at an edge
    task automatic settle_and_read();
        @(posedge core_clk);
        @(negedge core_clk);
        chk(got_vec, expect_vec(m));
        @(posedge core_clk);
        hdc_host_model_inst.xfer(CFG_ADDR, 1'b0, 3'h2, 32'h0, rd);
        chk(rd, {24'h0, m});
    endtask

    // Write, update the model only where the slave accepts it, then compare
    task automatic wr_chk(input logic [31:0] a, input logic [2:0] s, input logic [31:0] v);
        hdc_host_model_inst.xfer(a, 1'b1, s, v, rd);
        if (a[7:0] == HDC_CFG_OFFSET && s == HDC_HSIZE_WORD) m = v[7:0];
        settle_and_read();
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 500 cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        complete_run();
    end

    // Main sequence
    initial begin
        m = 8'ha0; // Gate code 2, rotating mass open loop, rest zero
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        settle_and_read();
        $display("test reset done");
        // Every gate code, other bits random, upper bus bits random too
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            d[7:6] = i[1:0];
            wr_chk(CFG_ADDR, 3'h2, d);
        end
        repeat (8) wr_chk(CFG_ADDR, 3'h2, $random(seed));
        $display("test fields done");
        // Writes elsewhere or of byte size leave the register alone
        wr_chk(32'h4, 3'h2, $random(seed));
        wr_chk(CFG_ADDR, 3'h0, $random(seed));
        hdc_host_model_inst.xfer(32'h4, 1'b0, 3'h2, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test refused done");
        // Host settles on closed loop drive with open-loop resonant PWM recovery
        wr_chk(CFG_ADDR, 3'h2, 32'h41);
        $display("test closed loop done");
        complete_run();
    end
endmodule
